// file: core/lcdirq_clkdiv.sv
`timescale 1ns/1ps
module lcdirq_clkdiv #(
	parameter int WIDTH = 10
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic [WIDTH-1:0] i_divider,
	output logic o_pixel_clock
);
	logic [WIDTH-1:0] count_q; // Half period counter
	logic pix_q; // Pixel clock level

	// Toggle every divider+1 cycles: period 2*(div+1)
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			count_q <= '0;
			pix_q <= 1'b0;
		end else if (count_q >= i_divider) begin
			count_q <= '0;
			pix_q <= ~pix_q;
		end else begin
			count_q <= count_q + 1'b1;
		end
	end

	assign o_pixel_clock = pix_q;
endmodule : lcdirq_clkdiv

// file: core/lcdirq_params.svh
// Summary of operation
// - Frame request sets pending bit 1
// - FIFO trigger level sets pending bit 0
// - Source pending keeps both raw requests
// - Mask resets to 0x3, both masked
// - Mask bit 0 serves, 1 blocks
// - Mask bit 2 picks 4 or 8 words
// - Timing chip control, reset 0x4
// - Divider field sets pixel clock rate
// - Rate is width*height*frames*mode factor
// - Factor 1/4,1/8 mono/gray; 3/4,3/8 color
// - Four-level gray packs 8 pixels/halfword
`ifndef LCDIRQ_PARAMS_SVH
`define LCDIRQ_PARAMS_SVH

// Register byte addresses
`define LCDIRQ_ADDR_PIXCTL 32'h4d000000
`define LCDIRQ_ADDR_GEOM 32'h4d000004
`define LCDIRQ_ADDR_RATE 32'h4d000008
`define LCDIRQ_ADDR_STATUS 32'h4d00000c
`define LCDIRQ_ADDR_UBASE 32'h4d000010
`define LCDIRQ_ADDR_LBASE 32'h4d000014
`define LCDIRQ_ADDR_INTPND 32'h4d000054
`define LCDIRQ_ADDR_SRCPND 32'h4d000058
`define LCDIRQ_ADDR_INTMSK 32'h4d00005c
`define LCDIRQ_ADDR_TCCTL 32'h4d000060

// Interrupt bit positions
`define LCDIRQ_BIT_FIFO 0
`define LCDIRQ_BIT_FRAME 1
`define LCDIRQ_BIT_DEPTH 2

// Reset values
`define LCDIRQ_RST_PND 2'h0
`define LCDIRQ_RST_MSK 3'h3
`define LCDIRQ_RST_TCCTL 4'h4

// FIFO trigger depths in words
`define LCDIRQ_DEPTH_LOW 5'h04
`define LCDIRQ_DEPTH_HIGH 5'h08

// Pixels per halfword per mode
`define LCDIRQ_PPH_MONO 5'h10
`define LCDIRQ_PPH_GRAY4 5'h08
`define LCDIRQ_PPH_GRAY16 5'h04
`define LCDIRQ_PPH_COLOR 5'h02

// Core clock rate in hertz
`define LCDIRQ_CLOCK_HZ 44'h00001312d00

`endif

// file: core/lcdirq_pkg.sv
package lcdirq_pkg;
	// Display pixel modes
	typedef enum logic [1:0] {
		LCDIRQ_MODE_MONO = 2'h0,
		LCDIRQ_MODE_GRAY4 = 2'h1,
		LCDIRQ_MODE_GRAY16 = 2'h2,
		LCDIRQ_MODE_COLOR = 2'h3
	} lcdirq_mode_t;
	// Two interrupt sources, frame at 1, FIFO at 0
	typedef logic [1:0] lcdirq_irq_t;
endpackage : lcdirq_pkg

// file: core/lcdirq_top.sv
`timescale 1ns/1ps
`include "lcdirq_params.svh"
module lcdirq_top #(
	parameter int DIV_WIDTH = 10,
	parameter int CNT_WIDTH = 5
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_frame_sync_req,
	input wire logic [CNT_WIDTH-1:0] i_fifo_word_count,
	output logic o_irq,
	output logic o_timing_chip_enable,
	output logic o_timing_chip_orientation_select,
	output logic o_timing_chip_mode_select,
	output logic o_timing_chip_vertical_clock_select,
	output logic o_pixel_clock,
	output logic [31:0] o_fetch_base,
	output logic [4:0] o_pixels_per_halfword,
	output lcdirq_pkg::lcdirq_irq_t o_source_pending
);
	import lcdirq_pkg::*;

	// Bus phase decode
	logic setup_phase; // First cycle of a transfer
	logic write_fire; // Write takes effect this edge
	logic [31:0] wdata; // Write data alias

	// Interrupt state
	lcdirq_irq_t srcpnd_q; // Raw source requests
	lcdirq_irq_t srcpnd_d;
	lcdirq_irq_t intpnd_q; // Unmasked serviced requests
	lcdirq_irq_t intpnd_d;
	logic [2:0] intmsk_q; // Depth select and two masks
	lcdirq_irq_t events; // Requests raised this cycle
	lcdirq_irq_t src_clr; // Write-one clear of source
	lcdirq_irq_t int_clr; // Write-one clear of pending
	logic irq_q; // Registered interrupt line

	// FIFO level tracking
	logic [CNT_WIDTH-1:0] fifo_level; // Chosen trigger depth
	logic fifo_reached; // Count at or above depth
	logic fifo_reached_q; // Previous comparison

	// Configuration state
	logic [3:0] tcctl_q; // Timing chip control bits
	logic [DIV_WIDTH-1:0] divider_q; // Pixel clock divider
	lcdirq_mode_t mode_q; // Pixel mode
	logic wide_scan_q; // 8-bit single or 4-bit dual scan
	logic [9:0] hsize_q; // Horizontal size in pixels
	logic [9:0] vsize_q; // Vertical size in lines
	logic [7:0] frame_rate_q; // Frames per second
	logic [31:0] ubase_q; // Upper frame base
	logic [31:0] lbase_q; // Lower frame base

	// Derived figures
	logic [31:0] rate_q; // Video data rate
	logic [31:0] rate_raw; // Rate before mode scaling
	logic [31:0] rate_scaled; // Rate after mode scaling
	logic rate_ok_q; // Pixel clock beats data rate
	logic [43:0] need_hz; // Rate times pixel period
	logic [4:0] pph_q; // Pixels per halfword
	logic [31:0] fetch_q; // Burst aligned fetch start

	// Readback
	logic [31:0] rdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] rd_mux; // Selected read value
	logic rd_hit; // Address is mapped

	// Pixels in one halfword of frame memory
	function automatic logic [4:0] pix_per_half(lcdirq_mode_t m);
		unique case (m)
			LCDIRQ_MODE_MONO: pix_per_half = `LCDIRQ_PPH_MONO;
			LCDIRQ_MODE_GRAY4: pix_per_half = `LCDIRQ_PPH_GRAY4;
			LCDIRQ_MODE_GRAY16: pix_per_half = `LCDIRQ_PPH_GRAY16;
			LCDIRQ_MODE_COLOR: pix_per_half = `LCDIRQ_PPH_COLOR;
		endcase
	endfunction : pix_per_half

	// Write strobe for one register address
	function automatic logic wr_at(logic fire, logic [31:0] a,
		logic [31:0] target);
		wr_at = fire && (a == target);
	endfunction : wr_at

	// Transfer phases
	assign setup_phase = i_psel && !i_penable;
	assign write_fire = i_psel && i_penable && pready_q && i_pwrite;
	assign wdata = i_pwdata;

	// Raised requests from the display engine
	assign fifo_level = intmsk_q[`LCDIRQ_BIT_DEPTH] ?
		`LCDIRQ_DEPTH_HIGH : `LCDIRQ_DEPTH_LOW;
	assign fifo_reached = i_fifo_word_count >= fifo_level;
	always_comb begin
		events = '0;
		events[`LCDIRQ_BIT_FRAME] = i_frame_sync_req;
		// Rising crossing of the trigger depth
		events[`LCDIRQ_BIT_FIFO] = fifo_reached && !fifo_reached_q;
	end

	// Remember last depth comparison
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			fifo_reached_q <= 1'b0;
		end else begin
			fifo_reached_q <= fifo_reached;
		end
	end

	// Write-one clears from software
	assign src_clr = wr_at(write_fire, i_paddr, `LCDIRQ_ADDR_SRCPND) ?
		wdata[1:0] : 2'h0;
	assign int_clr = wr_at(write_fire, i_paddr, `LCDIRQ_ADDR_INTPND) ?
		wdata[1:0] : 2'h0;

	// Next pending values, a new request beats a clear
	always_comb begin
		srcpnd_d = (srcpnd_q & ~src_clr) | events;
		// Forward only unmasked sources
		intpnd_d = (intpnd_q & ~int_clr) |
			((srcpnd_q | events) & ~intmsk_q[1:0]);
	end

	// Source pending register
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			srcpnd_q <= `LCDIRQ_RST_PND;
		end else begin
			srcpnd_q <= srcpnd_d;
		end
	end

	// Interrupt pending register
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			intpnd_q <= `LCDIRQ_RST_PND;
		end else begin
			intpnd_q <= intpnd_d;
		end
	end

	// Interrupt line follows pending bits
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |intpnd_d;
		end
	end

	// Mask and depth register
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			intmsk_q <= `LCDIRQ_RST_MSK;
		end else if (wr_at(write_fire, i_paddr, `LCDIRQ_ADDR_INTMSK)) begin
			intmsk_q <= wdata[2:0];
		end
	end

	// Timing chip control register
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			tcctl_q <= `LCDIRQ_RST_TCCTL;
		end else if (wr_at(write_fire, i_paddr, `LCDIRQ_ADDR_TCCTL)) begin
			tcctl_q <= wdata[3:0];
		end
	end

	// Pixel clock and mode register
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			divider_q <= '0;
			mode_q <= LCDIRQ_MODE_MONO;
			wide_scan_q <= 1'b0;
		end else if (wr_at(write_fire, i_paddr, `LCDIRQ_ADDR_PIXCTL)) begin
			divider_q <= wdata[DIV_WIDTH-1:0];
			mode_q <= lcdirq_mode_t'(wdata[11:10]);
			wide_scan_q <= wdata[12];
		end
	end

	// Panel geometry register
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			hsize_q <= '0;
			vsize_q <= '0;
			frame_rate_q <= '0;
		end else if (wr_at(write_fire, i_paddr, `LCDIRQ_ADDR_GEOM)) begin
			hsize_q <= wdata[9:0];
			vsize_q <= wdata[19:10];
			frame_rate_q <= wdata[27:20];
		end
	end

	// Frame base registers, values chosen by software
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			ubase_q <= '0;
			lbase_q <= '0;
		end else begin
			if (wr_at(write_fire, i_paddr, `LCDIRQ_ADDR_UBASE)) begin
				ubase_q <= wdata;
			end
			if (wr_at(write_fire, i_paddr, `LCDIRQ_ADDR_LBASE)) begin
				lbase_q <= wdata;
			end
		end
	end

	// Data rate: size times frames, then mode factor
	assign rate_raw = 32'(hsize_q) * 32'(vsize_q) * 32'(frame_rate_q);
	always_comb begin
		rate_scaled = rate_raw;
		// Colour triples the raw rate
		if (mode_q == LCDIRQ_MODE_COLOR) begin
			rate_scaled = rate_raw * 32'h3;
		end
		// Quarter on narrow scan, eighth on wide or dual
		if (wide_scan_q) begin
			rate_scaled = rate_scaled >> 3;
		end else begin
			rate_scaled = rate_scaled >> 2;
		end
	end

	// Hertz needed: rate times pixel clock period in cycles
	assign need_hz = 44'(rate_q) * (44'({divider_q, 1'b0}) + 44'h2);

	// Derived status, refreshed every cycle
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			rate_q <= '0;
			rate_ok_q <= 1'b0;
			pph_q <= `LCDIRQ_PPH_MONO;
			fetch_q <= '0;
		end else begin
			rate_q <= rate_scaled;
			rate_ok_q <= need_hz < `LCDIRQ_CLOCK_HZ;
			pph_q <= pix_per_half(mode_q);
			// Bursts of four words need 16-byte alignment
			fetch_q <= {ubase_q[31:4], 4'h0};
		end
	end

	// Read multiplexer and address decode
	always_comb begin
		rd_mux = '0;
		rd_hit = 1'b1;
		unique case (i_paddr)
			`LCDIRQ_ADDR_PIXCTL:
				rd_mux = {19'h0, wide_scan_q, mode_q, divider_q};
			`LCDIRQ_ADDR_GEOM:
				rd_mux = {4'h0, frame_rate_q, vsize_q, hsize_q};
			`LCDIRQ_ADDR_RATE: rd_mux = rate_q;
			`LCDIRQ_ADDR_STATUS: rd_mux = {26'h0, pph_q, rate_ok_q};
			`LCDIRQ_ADDR_UBASE: rd_mux = ubase_q;
			`LCDIRQ_ADDR_LBASE: rd_mux = lbase_q;
			`LCDIRQ_ADDR_INTPND: rd_mux = {30'h0, intpnd_q};
			`LCDIRQ_ADDR_SRCPND: rd_mux = {30'h0, srcpnd_q};
			`LCDIRQ_ADDR_INTMSK: rd_mux = {29'h0, intmsk_q};
			`LCDIRQ_ADDR_TCCTL: rd_mux = {28'h0, tcctl_q};
			// Unmapped address answers with an error
			default: rd_hit = 1'b0;
		endcase
	end

	// Bus answer: one wait-free access after setup
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			pready_q <= setup_phase;
			// Capture answer in setup, hold through access
			if (setup_phase) begin
				pslverr_q <= !rd_hit;
				rdata_q <= (rd_hit && !i_pwrite) ? rd_mux : 32'h0;
			end else if (!i_psel) begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// Pixel clock generator
	lcdirq_clkdiv #(
		.WIDTH(DIV_WIDTH)
	) u_clkdiv (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_divider(divider_q),
		.o_pixel_clock(o_pixel_clock)
	);

	// Outputs, all from flip-flops
	assign o_prdata = rdata_q;
	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;
	assign o_irq = irq_q;
	assign o_timing_chip_enable = tcctl_q[0];
	assign o_timing_chip_orientation_select = tcctl_q[1];
	assign o_timing_chip_mode_select = tcctl_q[2];
	assign o_timing_chip_vertical_clock_select = tcctl_q[3];
	assign o_fetch_base = fetch_q;
	assign o_pixels_per_halfword = pph_q;
	assign o_source_pending = srcpnd_q;
endmodule : lcdirq_top

// file: tb/lcdirq_panel_model.sv
`timescale 1ns/1ps
module lcdirq_panel_model (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_frame_go, // Ask for one frame boundary
	input wire logic [4:0] i_fill, // Target FIFO occupancy
	output logic o_frame_sync_req,
	output logic [4:0] o_fifo_word_count
);
	// One-clock frame pulse, FIFO moves one word a clock
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			o_frame_sync_req <= 1'b0;
			o_fifo_word_count <= 5'h00;
		end else begin
			o_frame_sync_req <= i_frame_go;
			if (o_fifo_word_count < i_fill) begin
				o_fifo_word_count <= o_fifo_word_count + 5'h01;
			end else if (o_fifo_word_count > i_fill) begin
				o_fifo_word_count <= o_fifo_word_count - 5'h01;
			end
		end
	end
endmodule : lcdirq_panel_model

// file: tb/lcdirq_props.sv
`timescale 1ns/1ps
module lcdirq_props #(
	parameter int CNT_WIDTH = 5
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic i_frame_sync_req,
	input wire logic [CNT_WIDTH-1:0] i_fifo_word_count,
	input wire logic o_irq,
	input wire logic o_timing_chip_enable,
	input wire logic o_timing_chip_orientation_select,
	input wire logic o_timing_chip_mode_select,
	input wire lcdirq_pkg::lcdirq_irq_t o_source_pending
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	logic wr; // Completed write
	logic [2:0] msk_q; // Shadow of the mask register
	logic [CNT_WIDTH-1:0] lvl; // FIFO trigger level
	assign wr = i_psel && i_penable && o_pready && i_pwrite;
	assign lvl = msk_q[2] ? CNT_WIDTH'(8) : CNT_WIDTH'(4);
	// Track mask writes
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			msk_q <= 3'h3;
		end else if (wr && i_paddr == 32'h4d00005c) begin
			msk_q <= i_pwdata[2:0];
		end
	end
	property p_frame_src;
		i_frame_sync_req |=> o_source_pending[1];
	endproperty
	a_frame_src: assert property (p_frame_src)
		else $error("frame request not recorded");
	property p_fifo_src;
		i_fifo_word_count >= lvl && $past(i_fifo_word_count) < lvl
			|=> o_source_pending[0];
	endproperty
	a_fifo_src: assert property (p_fifo_src)
		else $error("fifo level event not recorded");
	property p_masked;
		msk_q[1:0] == 2'h3 && !o_irq |=> !o_irq;
	endproperty
	a_masked: assert property (p_masked)
		else $error("masked source raised irq");
	property p_open;
		i_frame_sync_req && !msk_q[1] |=> o_irq;
	endproperty
	a_open: assert property (p_open)
		else $error("unmasked frame gave no irq");
	property p_rise;
		$rose(o_irq) |-> o_source_pending != 2'h0;
	endproperty
	a_rise: assert property (p_rise)
		else $error("irq rose with no source");
	property p_w1c;
		wr && i_paddr == 32'h4d000054 && i_pwdata[1:0] == 2'h3 &&
			o_source_pending == 2'h0 && !i_frame_sync_req &&
			$stable(i_fifo_word_count) |=> !o_irq;
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("irq stayed after clear");
	property p_tc_rst;
		$rose(i_reset_n) |-> o_timing_chip_mode_select &&
			!o_timing_chip_enable && !o_timing_chip_orientation_select;
	endproperty
	a_tc_rst: assert property (p_tc_rst)
		else $error("timing chip control reset wrong");
	property p_tc_wr;
		wr && i_paddr == 32'h4d000060 |=>
			o_timing_chip_enable == $past(i_pwdata[0]) &&
			o_timing_chip_orientation_select == $past(i_pwdata[1]);
	endproperty
	a_tc_wr: assert property (p_tc_wr)
		else $error("timing chip control not written");
endmodule : lcdirq_props

// file: tb/lcdirq_top_bench.sv
`timescale 1ns/1ps
`include "lcdirq_params.svh"
module lcdirq_top_bench;
	import lcdirq_pkg::*;
	typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] x;} lcdirq_row_t;
	logic i_clock = 0, i_reset_n = 0, psel = 0, pen = 0, pwr = 0, go = 0;
	logic [31:0] paddr = 0, pwdata = 0, rd, prdata;
	logic err, pready, irq, pclk, fsync;
	logic perr, pk; // Error seen at the answer edge, pixel clock level
	logic [3:0] tc; // Timing chip pins, enable at bit 0
	logic [31:0] fb; // Fetch base output
	int dv, xr, xs, md, hp; // Rate scenario figures, half period count
	logic [4:0] fill = 0, cnt, pph;
	lcdirq_irq_t srcp;
	int num_errors = 0, n_tests = 0;
	// Write value, read-back value
	lcdirq_row_t rows [6] = '{'{`LCDIRQ_ADDR_INTMSK, 32'hffffffff, 32'h7},
		'{`LCDIRQ_ADDR_TCCTL, 32'hffffffff, 32'hf},
		'{`LCDIRQ_ADDR_TCCTL, 32'h0, 32'h0},
		'{`LCDIRQ_ADDR_UBASE, 32'h0c500000, 32'h0c500000},
		'{`LCDIRQ_ADDR_LBASE, 32'h0c503c00, 32'h0c503c00},
		'{`LCDIRQ_ADDR_INTMSK, 32'h3, 32'h3}};
	always #25 i_clock = ~i_clock;
	lcdirq_top DUT (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(err),
		.i_frame_sync_req(fsync), .i_fifo_word_count(cnt), .o_irq(irq),
		.o_timing_chip_enable(tc[0]),
		.o_timing_chip_orientation_select(tc[1]),
		.o_timing_chip_mode_select(tc[2]),
		.o_timing_chip_vertical_clock_select(tc[3]),
		.o_pixel_clock(pclk), .o_fetch_base(fb), .o_pixels_per_halfword(pph),
		.o_source_pending(srcp));
	lcdirq_panel_model PANEL (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_frame_go(go), .i_fill(fill), .o_frame_sync_req(fsync),
		.o_fifo_word_count(cnt));
	task automatic chk(input string n, input logic [31:0] x, g);
		n_tests++;
		if (g !== x) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	// One APB transfer, read data and error left in rd and perr
	task automatic apb(input logic w, input logic [31:0] a, d);
		int n;
		n = 0;
		@(posedge i_clock);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		pen <= 1;
		// Hold the request until pready is seen high at a rising edge
		do begin
			@(posedge i_clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) num_errors++;
		rd = prdata;
		perr = err;
		psel <= 0;
		pen <= 0;
	endtask : apb
	task automatic cyc(input int k);
		repeat (k) @(posedge i_clock);
		#1;
	endtask : cyc
	task automatic pulse;
		@(posedge i_clock) go <= 1;
		@(posedge i_clock) go <= 0;
		cyc(3);
	endtask : pulse
	// Clear source first, then pending
	task automatic clr(input logic [31:0] v);
		apb(1, `LCDIRQ_ADDR_SRCPND, v);
		apb(1, `LCDIRQ_ADDR_INTPND, 32'h3);
		cyc(1);
	endtask : clr
	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	// Watchdog
	initial begin
		#1000000;
		num_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (6) @(posedge i_clock);
		i_reset_n <= 1;
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].d);
			apb(0, rows[i].a, 0);
			chk("reg", rows[i].x, rd);
		end
		chk("fetch", 32'h0c500000, fb);
		pulse;
		chk("src", 32'h2, srcp);
		chk("irq", 0, irq);
		apb(1, `LCDIRQ_ADDR_INTMSK, 32'h1);
		cyc(2);
		chk("irq", 1, irq);
		apb(0, `LCDIRQ_ADDR_INTPND, 0);
		chk("pnd", 32'h2, rd);
		clr(32'h2);
		chk("irq", 0, irq);
		pulse;
		chk("irq", 1, irq);
		clr(32'h2);
		// FIFO level 4 then 8
		for (int k = 0; k < 2; k++) begin
			apb(1, `LCDIRQ_ADDR_INTMSK, 32'h2 | (k << 2));
			@(posedge i_clock) fill <= 5'(4 * k + 3);
			cyc(12);
			chk("irq", 0, irq);
			@(posedge i_clock) fill <= 5'(4 * k + 4);
			cyc(4);
			chk("irq", 1, irq);
			@(posedge i_clock) fill <= 0;
			cyc(12);
			clr(32'h1);
		end
		apb(0, 32'h4d000100, 0);
		chk("slverr", 1, perr);
		chk("rd_unmapped", 0, rd);
		for (int m = 0; m < 4; m++) begin
			apb(1, `LCDIRQ_ADDR_PIXCTL, m << 10);
			cyc(2);
			chk("pph", 32'h10 >> m, pph);
		end
		// Data rate and divider headroom: gray4 narrow, colour wide
		apb(1, `LCDIRQ_ADDR_GEOM, 160 | (160 << 10) | (80 << 20));
		for (int j = 0; j < 4; j++) begin
			dv = (j == 0) ? 18 : (j == 1) ? 19 : (j == 2) ? 12 : 13;
			xr = (j < 2) ? 160 * 160 * 80 / 4 : 160 * 160 * 80 * 3 / 8;
			md = (j < 2) ? 32'h400 : 32'h1c00;
			apb(1, `LCDIRQ_ADDR_PIXCTL, dv | md);
			cyc(3);
			apb(0, `LCDIRQ_ADDR_RATE, 0);
			chk("rate", xr, rd);
			apb(0, `LCDIRQ_ADDR_STATUS, 0);
			xs = ((j < 2) ? 16 : 4) +
				(xr * 2 * (dv + 1) < `LCDIRQ_CLOCK_HZ);
			chk("status", xs, rd);
		end
		// Pixel clock half period tracks the divider
		for (int j = 1; j < 3; j++) begin
			apb(1, `LCDIRQ_ADDR_PIXCTL, 3 * j);
			cyc(1);
			pk = pclk;
			hp = 0;
			while (pclk === pk && hp < 64) begin
				cyc(1);
				hp++;
			end
			pk = pclk;
			hp = 0;
			while (pclk === pk && hp < 64) begin
				cyc(1);
				hp++;
			end
			chk("pclk_half", 3 * j + 1, hp);
		end
		// Timing chip pins follow the control register
		for (int j = 0; j < 2; j++) begin
			apb(1, `LCDIRQ_ADDR_TCCTL, j ? 32'h6 : 32'h9);
			cyc(1);
			chk("tc_pins", j ? 32'h6 : 32'h9, tc);
		end
		// Leave a pending frame so the mid-run reset has work to do
		apb(1, `LCDIRQ_ADDR_INTMSK, 0);
		pulse;
		chk("irq", 1, irq);
		@(posedge i_clock) i_reset_n <= 0;
		repeat (6) @(posedge i_clock);
		i_reset_n <= 1;
		apb(0, `LCDIRQ_ADDR_INTMSK, 0);
		chk("msk", 32'h3, rd);
		apb(0, `LCDIRQ_ADDR_TCCTL, 0);
		chk("tcctl", 32'h4, rd);
		chk("irq_rst", 0, irq);
		chk("src_rst", 0, srcp);
		chk("tc_rst", 32'h4, tc);
		chk("pph_rst", 32'h10, pph);
		chk("fetch_rst", 0, fb);
		tally_and_finish;
	end
endmodule : lcdirq_top_bench
bind lcdirq_top lcdirq_props #(.CNT_WIDTH(CNT_WIDTH)) PROPS (
	.i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_pready(o_pready),
	.i_frame_sync_req(i_frame_sync_req),
	.i_fifo_word_count(i_fifo_word_count), .o_irq(o_irq),
	.o_timing_chip_enable(o_timing_chip_enable),
	.o_timing_chip_orientation_select(o_timing_chip_orientation_select),
	.o_timing_chip_mode_select(o_timing_chip_mode_select),
	.o_source_pending(o_source_pending));
